// ---- src/bsalu_pkg.sv ----
// Package with register offsets, field positions, opcodes and states of the byte ALU execution block.
package bsalu_pkg;
  // APB register byte offsets.
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_WORK = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_TBL_PTR = 8'h10;
  localparam logic [7:0] OFF_TBL_HIGH = 8'h14;
  localparam logic [7:0] OFF_BANK = 8'h18;
  localparam logic [7:0] OFF_DMEM_ADDR = 8'h1c;
  localparam logic [7:0] OFF_DMEM_DATA = 8'h20;
  localparam logic [7:0] OFF_PMEM_ADDR = 8'h24;
  localparam logic [7:0] OFF_PMEM_DATA = 8'h28;
  // Command register fields.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_BIT_LSB = 20;
  localparam int CMD_IMM_LSB = 24;
  // Flag register bit positions.
  localparam int FL_C = 0;
  localparam int FL_HC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int FL_SGN = 4;
  localparam int FL_MBZ = 5;
  localparam int FL_W = 6;
  // Reset values.
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  // Decimal adjust constants.
  localparam logic [7:0] DAA_LOW = 8'h06;
  localparam logic [7:0] DAA_HIGH = 8'h60;
  localparam logic [3:0] BCD_MAX = 4'h9;
  // Opcodes.
  localparam logic [4:0] OP_SUB_IMM = 5'h00;
  localparam logic [4:0] OP_NIBBLE_EXCHANGE = 5'h01;
  localparam logic [4:0] OP_NIBBLE_EXCHANGE_TO_WORK = 5'h02;
  localparam logic [4:0] OP_SKIP_ON_ZERO_BYTE = 5'h03;
  localparam logic [4:0] OP_SKIP_ON_ZERO_COPY = 5'h04;
  localparam logic [4:0] OP_SKIP_ON_ZERO_BIT = 5'h05;
  localparam logic [4:0] OP_TABLE_FETCH_PAGED = 5'h06;
  localparam logic [4:0] OP_TABLE_FETCH_LASTPAGE = 5'h07;
  localparam logic [4:0] OP_TABLE_FETCH_PAGED_PREINC = 5'h08;
  localparam logic [4:0] OP_TABLE_FETCH_LASTPAGE_PREINC = 5'h09;
  localparam logic [4:0] OP_EXCLUSIVE_OR_TO_WORK = 5'h0a;
  localparam logic [4:0] OP_EXCLUSIVE_OR_TO_MEM = 5'h0b;
  localparam logic [4:0] OP_EXCLUSIVE_OR_IMM = 5'h0c;
  localparam logic [4:0] OP_EXT_ADD_WITH_CARRY = 5'h10;
  localparam logic [4:0] OP_EXT_ADD_WITH_CARRY_TO_MEM = 5'h11;
  localparam logic [4:0] OP_EXT_ADD = 5'h12;
  localparam logic [4:0] OP_EXT_ADD_TO_MEM = 5'h13;
  localparam logic [4:0] OP_EXT_AND = 5'h14;
  localparam logic [4:0] OP_EXT_AND_TO_MEM = 5'h15;
  localparam logic [4:0] OP_EXT_CLEAR = 5'h16;
  localparam logic [4:0] OP_EXT_BIT_CLEAR = 5'h17;
  localparam logic [4:0] OP_EXT_INVERT = 5'h18;
  localparam logic [4:0] OP_EXT_INVERT_TO_WORK = 5'h19;
  localparam logic [4:0] OP_EXT_DECIMAL_ADJUST = 5'h1a;
  localparam logic [4:0] OP_EXT_DECREMENT = 5'h1b;
  // Execution states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DUMMY = 3'b100
  } bsalu_state_e;
endpackage : bsalu_pkg

// ---- src/bsalu_exec.sv ----
// Byte ALU execution datapath with skip, table read and extended forms, reached over APB.
// What this block does
// - Subtract immediate from work_reg; set all six flags; carry set means no borrow.
// - Exchange the two nibbles of the addressed data byte in place; no flag changes.
// - Put nibble-exchanged data byte into work_reg; memory and flags unchanged.
// - Read and rewrite byte; if zero, skip next instruction with one dummy cycle.
// - Copy byte to work_reg; if zero, skip via dummy cycle; no flag changes.
// - Skip next instruction via dummy cycle when the selected bit is zero.
// - Paged table read: low byte to data memory, high byte to latch, flags kept.
// - Last-page table read addressed by table_ptr_low only; same byte placement.
// - Increment table_ptr_low first, then perform the paged table read.
// - Increment table_ptr_low first, then perform the last-page table read.
// - XOR work_reg with byte or immediate into work_reg or memory; only Z changes.
// - Extended forms address any data memory section directly, ignoring the bank.
// - Add work_reg, byte and carry to work_reg or memory; all flags but multi-byte zero.
// - Add work_reg and byte without carry-in; all flags but multi-byte zero change.
// - AND work_reg with byte into work_reg or memory; only Z changes.
// - Clear addressed data byte to zero; no flag changes.
// - Clear the selected bit of the addressed byte; other bits and flags kept.
// - Replace addressed byte with its ones' complement; only Z changes.
// - Put ones' complement of the byte into work_reg; memory kept; Z updated.
// - Decimal adjust work_reg into memory by adding 06/60/66; only C may change.
// - Decrement the addressed byte in place; only Z changes.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module bsalu_exec
  import bsalu_pkg::*;
#(
  parameter int DAW = 10,
  parameter int PAW = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy,
  output logic skip_pulse
);
  localparam int BKW = DAW - 8;

  // Architectural state and memories.
  logic [7:0] dmem_r [0:(1 << DAW) - 1];
  logic [15:0] pmem_r [0:(1 << PAW) - 1];
  bsalu_state_e state_r, state_nxt;
  logic [7:0] work_r;
  logic [FL_W-1:0] flags_r;
  logic [7:0] table_ptr_low_r, table_ptr_high_r, table_high_byte_latch_r;
  logic [BKW-1:0] bank_r;
  logic [DAW-1:0] dadr_r;
  logic [PAW-1:0] padr_r;
  logic [4:0] op_r;
  logic [DAW-1:0] addr_r;
  logic [2:0] bit_r;
  logic [7:0] imm_r;
  logic skip_last_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, busy_r, skip_pulse_r;

  // APB decode: pready rises one cycle after setup, so every transfer has one wait-free access.
  wire setup = psel & ~penable;
  wire acc_wr = psel & penable & pwrite & pready_r & ~pslverr_r;
  wire idle = (state_r == ST_IDLE);
  wire hit_cmd = (paddr == OFF_CMD);
  wire mapped = hit_cmd | (paddr == OFF_STATUS) | (paddr == OFF_WORK) | (paddr == OFF_FLAGS)
              | (paddr == OFF_TBL_PTR) | (paddr == OFF_TBL_HIGH) | (paddr == OFF_BANK)
              | (paddr == OFF_DMEM_ADDR) | (paddr == OFF_DMEM_DATA) | (paddr == OFF_PMEM_ADDR)
              | (paddr == OFF_PMEM_DATA);
  // A command written while an instruction is still running would corrupt it, so it is refused.
  wire refuse = ~mapped | (pwrite & ~idle);
  wire wr_cmd = acc_wr & hit_cmd;
  wire wr_work = acc_wr & (paddr == OFF_WORK);
  wire wr_flags = acc_wr & (paddr == OFF_FLAGS);
  wire wr_ptr = acc_wr & (paddr == OFF_TBL_PTR);
  wire wr_bank = acc_wr & (paddr == OFF_BANK);
  wire wr_dadr = acc_wr & (paddr == OFF_DMEM_ADDR);
  wire wr_ddat = acc_wr & (paddr == OFF_DMEM_DATA);
  wire wr_padr = acc_wr & (paddr == OFF_PMEM_ADDR);
  wire wr_pdat = acc_wr & (paddr == OFF_PMEM_DATA);

  // Read mux, sampled in the setup cycle.
  wire [31:0] rd_mux =
      (paddr == OFF_CMD) ? {imm_r, 1'b0, bit_r, 12'(addr_r), 3'h0, op_r} :
      (paddr == OFF_STATUS) ? {30'h0, skip_last_r, ~idle} :
      (paddr == OFF_WORK) ? {24'h0, work_r} :
      (paddr == OFF_FLAGS) ? {26'h0, flags_r} :
      (paddr == OFF_TBL_PTR) ? {16'h0, table_ptr_high_r, table_ptr_low_r} :
      (paddr == OFF_TBL_HIGH) ? {24'h0, table_high_byte_latch_r} :
      (paddr == OFF_BANK) ? {24'h0, 8'(bank_r)} :
      (paddr == OFF_DMEM_ADDR) ? {16'h0, 16'(dadr_r)} :
      (paddr == OFF_DMEM_DATA) ? {24'h0, dmem_r[dadr_r]} :
      (paddr == OFF_PMEM_ADDR) ? {16'h0, 16'(padr_r)} :
      (paddr == OFF_PMEM_DATA) ? {16'h0, pmem_r[padr_r]} : 32'h0;

  // Operand fetch; extended opcodes carry a full address, others use bank plus offset.
  wire ext_op = op_r[4];
  wire [DAW-1:0] ea = ext_op ? addr_r : {bank_r, addr_r[7:0]};
  wire [7:0] mval = dmem_r[ea];
  wire [7:0] mswp = {mval[3:0], mval[7:4]};
  wire bit_sel = mval[bit_r];
  wire [7:0] table_ptr_low_inc = table_ptr_low_r + 8'h01;
  wire preinc = (op_r == OP_TABLE_FETCH_PAGED_PREINC) | (op_r == OP_TABLE_FETCH_LASTPAGE_PREINC);
  wire lastpg = (op_r == OP_TABLE_FETCH_LASTPAGE) | (op_r == OP_TABLE_FETCH_LASTPAGE_PREINC);
  wire [7:0] table_ptr_low_use = preinc ? table_ptr_low_inc : table_ptr_low_r;
  wire [15:0] paged_adr = {table_ptr_high_r, table_ptr_low_use};
  wire [PAW-1:0] tadr = lastpg ? {{(PAW - 8){1'b1}}, table_ptr_low_use} : paged_adr[PAW-1:0];
  wire [15:0] pword = pmem_r[tadr];

  // Adder shared by subtract and add; subtract adds the inverted operand plus one.
  wire is_sub = (op_r == OP_SUB_IMM);
  wire use_cin = (op_r == OP_EXT_ADD_WITH_CARRY) | (op_r == OP_EXT_ADD_WITH_CARRY_TO_MEM);
  wire [7:0] add_b = is_sub ? ~imm_r : mval;
  wire add_ci = is_sub | (use_cin & flags_r[FL_C]);
  wire [8:0] sum9 = {1'b0, work_r} + {1'b0, add_b} + {8'h00, add_ci};
  wire [4:0] half5 = {1'b0, work_r[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};
  wire add_ov = (work_r[7] == add_b[7]) & (sum9[7] != work_r[7]);
  // Decimal adjust offsets.
  wire daa_lo = (work_r[3:0] > BCD_MAX) | flags_r[FL_HC];
  wire daa_hi = (work_r[7:4] > BCD_MAX) | flags_r[FL_C];
  wire [8:0] daa9 = {1'b0, work_r} + {1'b0, (daa_lo ? DAA_LOW : 8'h00) | (daa_hi ? DAA_HIGH : 8'h00)};

  // Instruction result: value, destination and flags.
  logic [7:0] res;
  logic to_work, to_mem, set_z, set_arith, skip;
  logic [FL_W-1:0] fl_nxt;
  always_comb begin
    res = mval;
    to_work = 1'b0;
    to_mem = 1'b0;
    set_z = 1'b0;
    set_arith = 1'b0;
    skip = 1'b0;
    case (op_r)
      OP_SUB_IMM: begin
        res = sum9[7:0];
        to_work = 1'b1;
        set_arith = 1'b1;
      end
      OP_NIBBLE_EXCHANGE: begin
        res = mswp;
        to_mem = 1'b1;
      end
      OP_NIBBLE_EXCHANGE_TO_WORK: begin
        res = mswp;
        to_work = 1'b1;
      end
      OP_SKIP_ON_ZERO_BYTE: begin
        to_mem = 1'b1;
        skip = (mval == 8'h00);
      end
      OP_SKIP_ON_ZERO_COPY: begin
        to_work = 1'b1;
        skip = (mval == 8'h00);
      end
      OP_SKIP_ON_ZERO_BIT: begin
        skip = ~bit_sel;
      end
      OP_TABLE_FETCH_PAGED, OP_TABLE_FETCH_LASTPAGE,
      OP_TABLE_FETCH_PAGED_PREINC, OP_TABLE_FETCH_LASTPAGE_PREINC: begin
        res = pword[7:0];
        to_mem = 1'b1;
      end
      OP_EXCLUSIVE_OR_TO_WORK, OP_EXCLUSIVE_OR_TO_MEM: begin
        res = work_r ^ mval;
        to_work = (op_r == OP_EXCLUSIVE_OR_TO_WORK);
        to_mem = (op_r == OP_EXCLUSIVE_OR_TO_MEM);
        set_z = 1'b1;
      end
      OP_EXCLUSIVE_OR_IMM: begin
        res = work_r ^ imm_r;
        to_work = 1'b1;
        set_z = 1'b1;
      end
      OP_EXT_ADD_WITH_CARRY, OP_EXT_ADD_WITH_CARRY_TO_MEM, OP_EXT_ADD, OP_EXT_ADD_TO_MEM: begin
        res = sum9[7:0];
        to_work = ~op_r[0];
        to_mem = op_r[0];
        set_arith = 1'b1;
      end
      OP_EXT_AND, OP_EXT_AND_TO_MEM: begin
        res = work_r & mval;
        to_work = ~op_r[0];
        to_mem = op_r[0];
        set_z = 1'b1;
      end
      OP_EXT_CLEAR: begin
        res = 8'h00;
        to_mem = 1'b1;
      end
      OP_EXT_BIT_CLEAR: begin
        res = mval & ~(8'h01 << bit_r);
        to_mem = 1'b1;
      end
      OP_EXT_INVERT, OP_EXT_INVERT_TO_WORK: begin
        res = ~mval;
        to_work = op_r[0];
        to_mem = ~op_r[0];
        set_z = 1'b1;
      end
      OP_EXT_DECIMAL_ADJUST: begin
        res = daa9[7:0];
        to_mem = 1'b1;
      end
      OP_EXT_DECREMENT: begin
        res = mval - 8'h01;
        to_mem = 1'b1;
        set_z = 1'b1;
      end
      default: begin
        res = mval;
      end
    endcase
    // Flags not named by the instruction keep their value.
    fl_nxt = flags_r;
    if (set_z | set_arith) begin
      fl_nxt[FL_Z] = (res == 8'h00);
    end
    if (set_arith) begin
      fl_nxt[FL_C] = sum9[8];
      fl_nxt[FL_HC] = half5[4];
      fl_nxt[FL_OV] = add_ov;
      fl_nxt[FL_SGN] = ~(add_ov ^ sum9[7]);
    end
    if (is_sub) begin
      fl_nxt[FL_MBZ] = (res == 8'h00);
    end
    if (op_r == OP_EXT_DECIMAL_ADJUST) begin
      fl_nxt[FL_C] = flags_r[FL_C] | daa9[8];
    end
  end

  // Sequencer: a skip spends one extra dummy cycle before the block is idle again.
  wire exec = (state_r == ST_EXEC);
  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = wr_cmd ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_nxt = skip ? ST_DUMMY : ST_IDLE;
      ST_DUMMY: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State, command latch and bus answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      op_r <= 5'h00;
      addr_r <= '0;
      bit_r <= 3'h0;
      imm_r <= 8'h00;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      busy_r <= 1'b0;
      skip_pulse_r <= 1'b0;
      skip_last_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != ST_IDLE);
      skip_pulse_r <= exec & skip;
      pready_r <= setup;
      if (setup) begin
        prdata_r <= pwrite ? 32'h0 : rd_mux;
        pslverr_r <= refuse;
      end
      if (wr_cmd) begin
        op_r <= pwdata[CMD_OP_LSB +: 5];
        addr_r <= pwdata[CMD_ADDR_LSB +: DAW];
        bit_r <= pwdata[CMD_BIT_LSB +: 3];
        imm_r <= pwdata[CMD_IMM_LSB +: 8];
      end
      if (exec) begin
        skip_last_r <= skip;
      end
    end
  end

  // Programmer-visible registers; execution writes take priority over bus writes in one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_r <= WORK_RST;
      flags_r <= FLAGS_RST;
      table_ptr_low_r <= PTR_RST;
      table_ptr_high_r <= PTR_RST;
      table_high_byte_latch_r <= PTR_RST;
      bank_r <= '0;
      dadr_r <= '0;
      padr_r <= '0;
    end else begin
      if (exec & to_work) work_r <= res;
      else if (wr_work) work_r <= pwdata[7:0];
      if (exec) flags_r <= fl_nxt;
      else if (wr_flags) flags_r <= pwdata[FL_W-1:0];
      if (exec & preinc) table_ptr_low_r <= table_ptr_low_inc;
      else if (wr_ptr) table_ptr_low_r <= pwdata[7:0];
      if (wr_ptr) table_ptr_high_r <= pwdata[15:8];
      if (exec & (op_r >= OP_TABLE_FETCH_PAGED) & (op_r <= OP_TABLE_FETCH_LASTPAGE_PREINC)) begin
        table_high_byte_latch_r <= pword[15:8];
      end
      if (wr_bank) bank_r <= pwdata[BKW-1:0];
      if (wr_dadr) dadr_r <= pwdata[DAW-1:0];
      if (wr_padr) padr_r <= pwdata[PAW-1:0];
    end
  end

  // Memories hold no reset; software loads them over the bus.
  always_ff @(posedge pclk) begin
    if (exec & to_mem) dmem_r[ea] <= res;
    else if (wr_ddat) dmem_r[dadr_r] <= pwdata[7:0];
    if (wr_pdat) pmem_r[padr_r] <= pwdata[15:0];
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign busy = busy_r;
  assign skip_pulse = skip_pulse_r;

  // Checks on the datapath.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [7:0] exp_sub = work_r - imm_r;
  wire sub_nb = (work_r >= imm_r);
  sequence dummy_then_idle;
    (state_r == ST_DUMMY) && skip_pulse_r ##1 (state_r == ST_IDLE) && !busy_r;
  endsequence

  sub_result_a: assert property (exec && is_sub |=> work_r == $past(exp_sub)
    && flags_r[FL_C] == $past(sub_nb)) else $error("subtract result or carry wrong");
  nibble_mem_a: assert property (exec && op_r == OP_NIBBLE_EXCHANGE |=> dmem_r[$past(ea)] == $past(mswp)
    && flags_r == $past(flags_r)) else $error("nibble exchange in memory wrong");
  skip_seq_a: assert property (exec && skip |=> dummy_then_idle)
    else $error("skip did not take exactly one dummy cycle");
  noskip_a: assert property (exec && !skip |=> state_r == ST_IDLE && !skip_pulse_r)
    else $error("dummy cycle without skip");
  copy_zero_a: assert property (exec && op_r == OP_SKIP_ON_ZERO_COPY && mval == 8'h00
    |=> work_r == 8'h00 ##1 state_r == ST_IDLE) else $error("zero copy skip wrong");
  table_high_a: assert property (exec && op_r == OP_TABLE_FETCH_PAGED |=> table_high_byte_latch_r == $past(pword[15:8])
    && flags_r == $past(flags_r)) else $error("table high latch wrong");
  preinc_ptr_a: assert property (exec && preinc |=> table_ptr_low_r == $past(table_ptr_low_inc))
    else $error("table pointer not incremented");
  xor_zero_a: assert property (exec && set_z && !set_arith |=> flags_r[FL_Z] == ($past(res) == 8'h00)
    && flags_r[FL_C] == $past(flags_r[FL_C])) else $error("logic op flag wrong");
  add_carry_a: assert property (exec && !is_sub && set_arith |=> flags_r[FL_C] == $past(sum9[8]))
    else $error("add carry wrong");
  daa_only_c_a: assert property (exec && op_r == OP_EXT_DECIMAL_ADJUST
    |=> flags_r[FL_MBZ:FL_HC] == $past(flags_r[FL_MBZ:FL_HC])) else $error("adjust changed other flags");

  // Single-destination results, each held against the operands of the execute cycle.
  wire [7:0] bit_mask = 8'h01 << bit_r;
  wire tbl_op = (op_r >= OP_TABLE_FETCH_PAGED) & (op_r <= OP_TABLE_FETCH_LASTPAGE_PREINC);
  swap_work_a: assert property (exec && op_r == OP_NIBBLE_EXCHANGE_TO_WORK |=> work_r == $past(mswp)
    && dmem_r[$past(ea)] == $past(mval)) else $error("nibble exchange to work wrong");
  table_low_a: assert property (exec && tbl_op |=> dmem_r[$past(ea)] == $past(pword[7:0]))
    else $error("table low byte wrong");
  and_mem_a: assert property (exec && op_r == OP_EXT_AND_TO_MEM
    |=> dmem_r[$past(ea)] == ($past(work_r) & $past(mval))) else $error("and to memory wrong");
  clear_mem_a: assert property (exec && op_r == OP_EXT_CLEAR |=> dmem_r[$past(ea)] == 8'h00
    && flags_r == $past(flags_r)) else $error("clear wrong");
  bit_clear_a: assert property (exec && op_r == OP_EXT_BIT_CLEAR
    |=> dmem_r[$past(ea)] == ($past(mval) & ~$past(bit_mask))) else $error("bit clear wrong");
  invert_mem_a: assert property (exec && op_r == OP_EXT_INVERT |=> dmem_r[$past(ea)] == ~$past(mval))
    else $error("invert in memory wrong");
  invert_work_a: assert property (exec && op_r == OP_EXT_INVERT_TO_WORK |=> work_r == ~$past(mval)
    && dmem_r[$past(ea)] == $past(mval)) else $error("invert to work wrong");
  dec_mem_a: assert property (exec && op_r == OP_EXT_DECREMENT
    |=> dmem_r[$past(ea)] == $past(mval) - 8'h01 && flags_r[FL_Z] == ($past(mval) == 8'h01))
    else $error("decrement wrong");
endmodule : bsalu_exec

// ---- tb/bsalu_mem_ref.sv ----
// Shadow copy of the block's data and program memories, kept by the bench.
`timescale 1ns/1ns
module bsalu_mem_ref;
  // Sized for DAW = PAW = 10 as the bench instantiates the block.
  logic [7:0] dm [0:1023];
  logic [15:0] pm [0:1023];
endmodule : bsalu_mem_ref

// ---- tb/testbench.sv ----
// Self-checking bench for the byte ALU execution block.
`timescale 1ns/1ns
module testbench;
  import bsalu_pkg::*;
  localparam logic [3:0] K_Z = 4'h8;
  localparam logic [3:0] K_W = 4'h4;
  localparam logic [3:0] K_M = 4'h2;
  localparam logic [3:0] K_S = 4'h1;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, skip_pulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e, sk;
  bit on;
  int n_errors, compares, nsk, nbusy;
  int cyc = 0;
  logic [7:0] w = 8'h00;
  logic [7:0] th = 8'h00;
  logic [7:0] res, bank;
  logic [5:0] f;
  logic [15:0] tp;
  logic [9:0] da;
  bsalu_mem_ref mem ();
  bsalu_exec #(.DAW(10), .PAW(10)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .skip_pulse(skip_pulse));

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Counts skip pulses and busy cycles and stops a hung run; the ceiling is well above the planned traffic.
  always @(posedge pclk) begin
    cyc++;
    if (skip_pulse === 1'b1)
      nsk++;
    if (busy === 1'b1)
      nbusy++;
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer; with hold set the next setup follows at the same edge, without an idle cycle.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input bit hold = 0);
    int k;
    if (!on) begin
      @(posedge pclk);
      psel <= 1'b1;
    end
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1)
      n_errors++;
    penable <= 1'b0;
    if (!hold)
      psel <= 1'b0;
    on = hold;
  endtask : apb

  // Writes a result to its destinations and updates the zero and skip state.
  function automatic void set(input logic [7:0] v, input logic [3:0] k);
    res = v;
    if (k[3])
      f[FL_Z] = (v == 8'h00);
    if (k[2])
      w = v;
    if (k[1])
      mem.dm[da] = v;
    if (k[0])
      sk = (v == 8'h00);
  endfunction : set

  function automatic void add8(input logic [7:0] x, input logic [7:0] y, input logic ci, input logic [3:0] k);
    logic [8:0] s;
    s = {1'b0, x} + {1'b0, y} + 9'(ci);
    f[FL_C] = s[8];
    f[FL_HC] = ({1'b0, x[3:0]} + {1'b0, y[3:0]} + 5'(ci)) > 5'h0f;
    f[FL_OV] = (x[7] == y[7]) && (s[7] != x[7]);
    f[FL_SGN] = ~(f[FL_OV] ^ s[7]);
    set(s[7:0], k | K_Z);
  endfunction : add8

  // Borrow shows as a cleared carry, so the subtraction is an add of the inverse plus one.
  function automatic void sub(input logic [7:0] x);
    add8(w, ~x, 1'b1, K_W);
    f[FL_MBZ] = f[FL_Z];
  endfunction : sub

  function automatic void tbl(input logic paged, input logic inc);
    logic [9:0] pa;
    if (inc)
      tp[7:0] = tp[7:0] + 8'h01;
    pa = paged ? tp[9:0] : {2'b11, tp[7:0]};
    th = mem.pm[pa][15:8];
    set(mem.pm[pa][7:0], K_M);
  endfunction : tbl

  // The adjustment is chosen from the nibbles as they stood before the add.
  function automatic void daa();
    logic [8:0] s;
    s = {1'b0, w} + ((w[3:0] > 4'h9 || f[FL_HC]) ? 9'h006 : 9'h000) + ((w[7:4] > 4'h9 || f[FL_C]) ? 9'h060 : 9'h000);
    f[FL_C] = f[FL_C] | s[8];
    set(s[7:0], K_M);
  endfunction : daa

  // Loads operands, runs one command, mirrors it and compares every visible result.
  task automatic run(input logic [4:0] op, input logic [9:0] a, input logic [2:0] bt, input logic [7:0] imm,
                     input logic [7:0] wv, input logic [7:0] m, input logic [5:0] fv);
    int k, n0, b0;
    w = wv;
    f = fv;
    sk = 1'b0;
    bank = 8'($urandom_range(0, 3));
    tp = 16'($urandom);
    da = (op < 5'h10) ? {bank[1:0], a[7:0]} : a;
    mem.dm[da] = m;
    apb(1, OFF_WORK, 32'(w));
    apb(1, OFF_FLAGS, 32'(f));
    apb(1, OFF_BANK, 32'(bank));
    apb(1, OFF_TBL_PTR, 32'(tp));
    apb(1, OFF_DMEM_ADDR, 32'(da));
    apb(1, OFF_DMEM_DATA, 32'(m));
    n0 = nsk;
    b0 = nbusy;
    apb(1, OFF_CMD, {imm, 1'b0, bt, 2'b00, a, 3'b000, op});
    chk("command error", 32'h0, 32'(e));
    case (op)
      OP_SUB_IMM: sub(imm);
      OP_NIBBLE_EXCHANGE: set({m[3:0], m[7:4]}, K_M);
      OP_NIBBLE_EXCHANGE_TO_WORK: set({m[3:0], m[7:4]}, K_W);
      OP_SKIP_ON_ZERO_BYTE: set(m, K_S);
      OP_SKIP_ON_ZERO_COPY: set(m, K_W | K_S);
      OP_SKIP_ON_ZERO_BIT: sk = ~m[bt];
      OP_TABLE_FETCH_PAGED: tbl(1'b1, 1'b0);
      OP_TABLE_FETCH_LASTPAGE: tbl(1'b0, 1'b0);
      OP_TABLE_FETCH_PAGED_PREINC: tbl(1'b1, 1'b1);
      OP_TABLE_FETCH_LASTPAGE_PREINC: tbl(1'b0, 1'b1);
      OP_EXCLUSIVE_OR_TO_WORK: set(w ^ m, K_Z | K_W);
      OP_EXCLUSIVE_OR_TO_MEM: set(w ^ m, K_Z | K_M);
      OP_EXCLUSIVE_OR_IMM: set(w ^ imm, K_Z | K_W);
      OP_EXT_ADD_WITH_CARRY: add8(w, m, f[FL_C], K_W);
      OP_EXT_ADD_WITH_CARRY_TO_MEM: add8(w, m, f[FL_C], K_M);
      OP_EXT_ADD: add8(w, m, 1'b0, K_W);
      OP_EXT_ADD_TO_MEM: add8(w, m, 1'b0, K_M);
      OP_EXT_AND: set(w & m, K_Z | K_W);
      OP_EXT_AND_TO_MEM: set(w & m, K_Z | K_M);
      OP_EXT_CLEAR: set(8'h00, K_M);
      OP_EXT_BIT_CLEAR: set(m & ~(8'h01 << bt), K_M);
      OP_EXT_INVERT: set(~m, K_Z | K_M);
      OP_EXT_INVERT_TO_WORK: set(~m, K_Z | K_W);
      OP_EXT_DECIMAL_ADJUST: daa();
      OP_EXT_DECREMENT: set(m - 8'h01, K_Z | K_M);
      default: ;
    endcase
    k = 0;
    do begin
      apb(0, OFF_STATUS, 32'h0);
      k++;
    end while (r[0] !== 1'b0 && k < 20);
    chk("skip status", 32'(sk), 32'(r[1]));
    chk("skip pulses", 32'(sk), 32'(nsk - n0));
    chk("busy status", 32'h0, 32'(r[0]));
    chk("busy cycles", 32'(sk) + 32'h1, 32'(nbusy - b0));
    apb(0, OFF_WORK, 32'h0);
    chk("work", 32'(w), r);
    apb(0, OFF_FLAGS, 32'h0);
    chk("flags", 32'(f), r);
    apb(0, OFF_TBL_PTR, 32'h0);
    chk("table pointer", 32'(tp), r);
    apb(0, OFF_TBL_HIGH, 32'h0);
    chk("table latch", 32'(th), r);
    apb(0, OFF_DMEM_DATA, 32'h0);
    chk("data byte", 32'(mem.dm[da]), r);
    $display("test op %h at %h done", op, da);
  endtask : run

  // Main sequence: reset, memory load, every opcode, corners, random traffic, refusals.
  initial begin
    logic [7:0] regs [6];
    regs = '{OFF_WORK, OFF_FLAGS, OFF_TBL_PTR, OFF_TBL_HIGH, OFF_BANK, OFF_STATUS};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'h41dc9020));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) begin
      apb(0, regs[i], 32'h0);
      chk("reset value", 32'h0, r);
    end
    apb(0, 8'h30, 32'h0);
    chk("unmapped error", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, r);
    for (int i = 0; i < 1024; i++) begin
      mem.dm[i] = 8'($urandom);
      mem.pm[i] = 16'($urandom);
      apb(1, OFF_DMEM_ADDR, 32'(i));
      apb(1, OFF_DMEM_DATA, 32'(mem.dm[i]));
      apb(1, OFF_PMEM_ADDR, 32'(i));
      apb(1, OFF_PMEM_DATA, 32'(mem.pm[i]));
    end
    // Each code, unused ones too, meets a zero byte, an all-ones byte and a random byte.
    for (int i = 0; i < 96; i++)
      run(5'(i / 3), 10'($urandom), 3'($urandom), 8'($urandom), 8'($urandom),
          (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'hff : 8'($urandom), 6'($urandom));
    run(OP_SUB_IMM, 10'h3ff, 3'h0, 8'h35, 8'h35, 8'h00, 6'h00);
    run(OP_EXT_ADD, 10'h2c4, 3'h0, 8'h00, 8'h7f, 8'h01, 6'h00);
    run(OP_EXT_ADD_WITH_CARRY, 10'h155, 3'h0, 8'h00, 8'hff, 8'h00, 6'h01);
    run(OP_EXT_DECIMAL_ADJUST, 10'h301, 3'h0, 8'h00, 8'h9a, 8'h00, 6'h00);
    run(OP_EXT_DECIMAL_ADJUST, 10'h302, 3'h0, 8'h00, 8'h99, 8'h00, 6'h03);
    repeat (200)
      run(5'($urandom_range(0, 27)), 10'($urandom), 3'($urandom), 8'($urandom), 8'($urandom),
          8'($urandom), 6'($urandom));
    // A second command while the first still runs is refused and leaves no trace.
    apb(1, OFF_CMD, 32'h1100_0000, 1);
    apb(1, OFF_CMD, 32'h1100_0000);
    chk("busy write error", 32'h1, 32'(e));
    sub(8'h11);
    apb(0, OFF_WORK, 32'h0);
    chk("work after refusal", 32'(w), r);
    $display("test refusal done");
    stop_test();
  end
endmodule : testbench
